// *** tct_defs.vh ***
// register map, field positions, mode and state codes and address windows of the transfer controller
// assumes a 32-bit apb slave with byte addresses and a 24-bit linear data space
`ifndef TCT_DEFS_VH
`define TCT_DEFS_VH
// global registers
`define TCT_GCTRL       8'h00
`define TCT_GSTAT       8'h04
// channel n occupies 8'h20*(n+1) .. 8'h20*(n+1)+8'h14
`define TCT_CH_SHIFT    5
`define TCT_CTRL        5'h00
`define TCT_SRC         5'h04
`define TCT_DST         5'h08
`define TCT_CNT         5'h0c
`define TCT_REP         5'h10
`define TCT_STAT        5'h14
// global control fields
`define TCT_G_EN        0
`define TCT_G_RR        1
`define TCT_G_EEMAP     2
// channel control fields
`define TCT_C_EN        0
`define TCT_C_RELOAD    1
`define TCT_C_SMODE_LO  2
`define TCT_C_DMODE_LO  4
`define TCT_C_BURST_LO  6
`define TCT_C_TRIG_LO   8
`define TCT_C_LINK      10
`define TCT_C_SWTRIG    11
`define TCT_C_WIDTH     11
// channel status fields
`define TCT_S_DONE      0
`define TCT_S_ERR       1
`define TCT_S_PEND      2
`define TCT_S_ACT       3
// address stepping modes
`define TCT_AM_HOLD     2'h0
`define TCT_AM_INC      2'h1
`define TCT_AM_DEC      2'h2
// trigger selections
`define TCT_TS_SW       2'h0
`define TCT_TS_PER0     2'h1
`define TCT_TS_PER1     2'h2
`define TCT_TS_EVT      2'h3
// data space windows, fixed for every device size
`define TCT_EE_BASE     24'h001000
`define TCT_EE_END      24'h001fff
// engine states
`define TCT_ST_IDLE     2'h0
`define TCT_ST_RD       2'h1
`define TCT_ST_WR       2'h2
`endif

// *** tct_dma.v ***
// four-channel byte mover on the shared data bus, programmed over apb
// assumes an outside arbiter grants the data bus and a bus slave answers with bus_rdy
`include "tct_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module tct_dma (
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // shared data bus master
   output reg         bus_req,
   input  wire        bus_gnt,
   input  wire        bus_rdy,
   output reg  [23:0] bus_addr,
   output reg         bus_we,
   output reg  [7:0]  bus_wdata,
   input  wire [7:0]  bus_rdata,
   // trigger sources
   input  wire [7:0]  periph_trig,
   input  wire [3:0]  evt_trig
);

   // global configuration
   reg [2:0]  gctrl_q;                    // enable, round robin, eeprom mapped
   // per-channel programmed values
   reg [`TCT_C_WIDTH-1:0] ctrl_q [0:3];   // channel control
   reg [23:0] src_prog_q [0:3];           // starting source address
   reg [23:0] dst_prog_q [0:3];           // starting destination address
   reg [15:0] cnt_prog_q [0:3];           // block length, 0 means 64K
   reg [7:0]  rep_prog_q [0:3];           // extra blocks after the first
   // per-channel working values
   reg [23:0] src_q [0:3];                // current source address
   reg [23:0] dst_q [0:3];                // current destination address
   reg [15:0] cnt_q [0:3];                // bytes left in block
   reg [7:0]  rep_q [0:3];                // blocks left after this one
   reg [3:0]  done_q;                     // sticky completion flags
   reg [3:0]  err_q;                      // sticky error flags
   reg [3:0]  pend_q;                     // trigger waiting for a burst
   // engine
   reg [1:0]  state_q;                    // idle, read, write
   reg [1:0]  cur_q;                      // channel owning the engine
   reg [3:0]  left_q;                     // bytes left in this burst
   reg [1:0]  last_q;                     // last channel served, for round robin

   // apb decode
   wire       apb_acc  = psel & penable;
   wire       apb_wr   = apb_acc & pready & pwrite;
   wire [1:0] a_ch     = paddr[6:5] - 2'h1;
   wire       a_is_ch  = (paddr[7:5] != 3'h0) && (paddr[7:5] <= 3'h4);
   wire [4:0] a_off    = paddr[4:0];
   wire       a_glob   = (paddr == `TCT_GCTRL) || (paddr == `TCT_GSTAT);
   wire       a_chok   = a_is_ch && (a_off <= `TCT_STAT) && (a_off[1:0] == 2'h0);
   wire       a_map    = a_glob | a_chok;
   // software trigger written this cycle, one bit per channel
   wire [3:0] sw_set   = (apb_wr && a_chok && (a_off == `TCT_CTRL) && pwdata[`TCT_C_SWTRIG]) ?
                         (4'h1 << a_ch) : 4'h0;

   // next-address stepping, same function for both sides
   function [23:0] step;
      input [23:0] a;
      input [1:0]  m;
      begin
         case (m)
            `TCT_AM_INC: step = a + 24'h000001;
            `TCT_AM_DEC: step = a - 24'h000001;
            default:     step = a;
         endcase
      end
   endfunction

   // eeprom window check on the linear map
   function in_ee;
      input [23:0] a;
      begin
         in_ee = (a >= `TCT_EE_BASE) && (a <= `TCT_EE_END);
      end
   endfunction

   // burst length decode, 1 2 4 8
   function [3:0] blen;
      input [1:0] b;
      begin
         blen = 4'h1 << b;
      end
   endfunction

   // selected hardware trigger per channel, each channel its own lanes
   reg [3:0] hw_trig;
   integer   t;
   always @* begin
      hw_trig = 4'h0;
      for (t = 0; t < 4; t = t + 1) begin
         case (ctrl_q[t][`TCT_C_TRIG_LO+1:`TCT_C_TRIG_LO])
            `TCT_TS_PER0: hw_trig[t] = periph_trig[2*t];
            `TCT_TS_PER1: hw_trig[t] = periph_trig[2*t+1];
            `TCT_TS_EVT:  hw_trig[t] = evt_trig[t];
            default:      hw_trig[t] = 1'b0;
         endcase
      end
   end

   // channels ready to run a burst
   reg [3:0] ready_v;
   integer   r;
   always @* begin
      ready_v = 4'h0;
      for (r = 0; r < 4; r = r + 1) begin
         ready_v[r] = ctrl_q[r][`TCT_C_EN] & pend_q[r];
      end
   end

   // priority pick: fixed ch0 first, or round robin after last served
   reg [1:0] pick;
   reg       pick_ok;
   reg [1:0] cand;
   integer   p;
   always @* begin
      pick    = 2'h0;
      pick_ok = 1'b0;
      cand    = 2'h0;
      for (p = 3; p >= 0; p = p - 1) begin
         cand = gctrl_q[`TCT_G_RR] ? (last_q + 2'h1 + p[1:0]) : p[1:0];
         if (ready_v[cand]) begin
            pick    = cand;
            pick_ok = 1'b1;
         end
      end
   end

   // apb answer: one wait state, then registered data
   reg [31:0] rd_v;
   always @* begin
      rd_v = 32'h00000000;
      if (paddr == `TCT_GCTRL) begin
         rd_v = {29'h0, gctrl_q};
      end else if (paddr == `TCT_GSTAT) begin
         rd_v = {24'h0, done_q | err_q, 1'b0, state_q != `TCT_ST_IDLE, cur_q};
      end else if (a_chok) begin
         case (a_off)
            `TCT_CTRL: rd_v = {21'h0, ctrl_q[a_ch]};
            `TCT_SRC:  rd_v = {8'h0, src_q[a_ch]};
            `TCT_DST:  rd_v = {8'h0, dst_q[a_ch]};
            `TCT_CNT:  rd_v = {16'h0, cnt_q[a_ch]};
            `TCT_REP:  rd_v = {24'h0, rep_q[a_ch]};
            `TCT_STAT: rd_v = {28'h0, (state_q != `TCT_ST_IDLE) && (cur_q == a_ch),
                               pend_q[a_ch], err_q[a_ch], done_q[a_ch]};
            default:   rd_v = 32'h00000000;
         endcase
      end
   end

   // apb handshake flops
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         // pready pulses for one cycle per access phase
         pready  <= apb_acc & ~pready;
         prdata  <= (apb_acc & ~pready & ~pwrite) ? rd_v : 32'h00000000;
         pslverr <= apb_acc & ~pready & ~a_map;
      end
   end

   // engine view of the owning channel
   wire [`TCT_C_WIDTH-1:0] cc = ctrl_q[cur_q];
   wire [23:0] nsrc  = step(src_q[cur_q], cc[`TCT_C_SMODE_LO+1:`TCT_C_SMODE_LO]);
   wire [23:0] ndst  = step(dst_q[cur_q], cc[`TCT_C_DMODE_LO+1:`TCT_C_DMODE_LO]);
   wire        blk_end = (cnt_q[cur_q] == 16'h0001);
   wire        txn_end = blk_end && (rep_q[cur_q] == 8'h00);
   wire        xfer  = bus_req & bus_gnt & bus_rdy;
   wire [1:0]  pk_ch = pick;
   wire        ee_rd_bad = in_ee(src_q[pk_ch]) & ~gctrl_q[`TCT_G_EEMAP];

   // channel state and engine share one process so each flop has one driver;
   // engine updates come last so they win over a colliding apb write,
   // and flag sets follow flag clears so a set in the clearing cycle holds
   integer i;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gctrl_q   <= 3'h0;
         done_q    <= 4'h0;
         err_q     <= 4'h0;
         pend_q    <= 4'h0;
         state_q   <= `TCT_ST_IDLE;
         cur_q     <= 2'h0;
         left_q    <= 4'h0;
         last_q    <= 2'h3;
         bus_req   <= 1'b0;
         bus_addr  <= 24'h000000;
         bus_we    <= 1'b0;
         bus_wdata <= 8'h00;
         for (i = 0; i < 4; i = i + 1) begin
            ctrl_q[i]     <= {`TCT_C_WIDTH{1'b0}};
            src_prog_q[i] <= 24'h000000;
            dst_prog_q[i] <= 24'h000000;
            cnt_prog_q[i] <= 16'h0000;
            rep_prog_q[i] <= 8'h00;
            src_q[i]      <= 24'h000000;
            dst_q[i]      <= 24'h000000;
            cnt_q[i]      <= 16'h0000;
            rep_q[i]      <= 8'h00;
         end
      end else begin
         // hardware triggers arm their channel
         pend_q <= pend_q | hw_trig;
         // software programming, each channel on its own
         if (apb_wr && (paddr == `TCT_GCTRL)) begin
            gctrl_q <= pwdata[2:0];
         end
         if (apb_wr && a_chok) begin
            case (a_off)
               `TCT_CTRL: begin
                  // link bit is kept; the trigger bit lies above the stored field
                  ctrl_q[a_ch] <= pwdata[`TCT_C_WIDTH-1:0];
                  if (pwdata[`TCT_C_SWTRIG]) begin
                     pend_q[a_ch] <= 1'b1;
                  end
               end
               `TCT_SRC: begin
                  src_prog_q[a_ch] <= pwdata[23:0];
                  src_q[a_ch]      <= pwdata[23:0];
               end
               `TCT_DST: begin
                  dst_prog_q[a_ch] <= pwdata[23:0];
                  dst_q[a_ch]      <= pwdata[23:0];
               end
               `TCT_CNT: begin
                  cnt_prog_q[a_ch] <= pwdata[15:0];
                  cnt_q[a_ch]      <= pwdata[15:0];
               end
               `TCT_REP: begin
                  rep_prog_q[a_ch] <= pwdata[7:0];
                  rep_q[a_ch]      <= pwdata[7:0];
               end
               `TCT_STAT: begin
                  // write one to clear
                  done_q[a_ch] <= done_q[a_ch] & ~pwdata[`TCT_S_DONE];
                  err_q[a_ch]  <= err_q[a_ch] & ~pwdata[`TCT_S_ERR];
               end
               default: begin
               end
            endcase
         end
         // transfer engine
         case (state_q)
            `TCT_ST_IDLE: begin
               if (gctrl_q[`TCT_G_EN] && pick_ok) begin
                  cur_q         <= pk_ch;
                  last_q        <= pk_ch;
                  // a software trigger landing in the clearing cycle survives
                  pend_q[pk_ch] <= hw_trig[pk_ch] | sw_set[pk_ch];
                  if (ee_rd_bad) begin
                     // unmapped eeprom read: refuse, stop channel
                     err_q[pk_ch]            <= 1'b1;
                     ctrl_q[pk_ch][`TCT_C_EN] <= 1'b0;
                  end else begin
                     left_q   <= blen(ctrl_q[pk_ch][`TCT_C_BURST_LO+1:`TCT_C_BURST_LO]);
                     bus_req  <= 1'b1;
                     bus_we   <= 1'b0;
                     bus_addr <= src_q[pk_ch];
                     state_q  <= `TCT_ST_RD;
                  end
               end
            end
            `TCT_ST_RD: begin
               // request holds unchanged until granted and answered
               if (xfer) begin
                  if (in_ee(dst_q[cur_q])) begin
                     // eeprom is never a destination
                     err_q[cur_q]            <= 1'b1;
                     ctrl_q[cur_q][`TCT_C_EN] <= 1'b0;
                     bus_req                 <= 1'b0;
                     state_q                 <= `TCT_ST_IDLE;
                  end else begin
                     bus_wdata <= bus_rdata;
                     bus_addr  <= dst_q[cur_q];
                     bus_we    <= 1'b1;
                     state_q   <= `TCT_ST_WR;
                  end
               end
            end
            `TCT_ST_WR: begin
               if (xfer) begin
                  src_q[cur_q] <= nsrc;
                  dst_q[cur_q] <= ndst;
                  cnt_q[cur_q] <= cnt_q[cur_q] - 16'h0001;
                  left_q       <= left_q - 4'h1;
                  bus_we       <= 1'b0;
                  if (blk_end) begin
                     cnt_q[cur_q] <= cnt_prog_q[cur_q];
                     rep_q[cur_q] <= rep_q[cur_q] - 8'h01;
                  end
                  if (txn_end) begin
                     rep_q[cur_q]            <= rep_prog_q[cur_q];
                     done_q[cur_q]           <= 1'b1;
                     ctrl_q[cur_q][`TCT_C_EN] <= 1'b0;
                     if (cc[`TCT_C_RELOAD]) begin
                        src_q[cur_q] <= src_prog_q[cur_q];
                        dst_q[cur_q] <= dst_prog_q[cur_q];
                     end
                     if (cc[`TCT_C_LINK]) begin
                        // partner of a pair takes over the stream
                        ctrl_q[cur_q ^ 2'h1][`TCT_C_EN] <= 1'b1;
                     end
                  end
                  if (blk_end || (left_q == 4'h1)) begin
                     // burst over: give the bus back, re-arbitrate
                     bus_req <= 1'b0;
                     state_q <= `TCT_ST_IDLE;
                  end else begin
                     bus_addr <= nsrc;
                     state_q  <= `TCT_ST_RD;
                  end
               end
            end
            default: begin
               bus_req <= 1'b0;
               state_q <= `TCT_ST_IDLE;
            end
         endcase
      end
   end

endmodule // tct_dma

`default_nettype wire

// *** tct_dma_asserts.sv ***
// port assertions for the transfer controller, apb side and shared data bus side
// assumes a bind onto tct_dma with one clock pclk and async active-low presetn
`timescale 1ns/1ps
`default_nettype none
module tct_dma_asserts (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb answer
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // data bus
   input wire logic        bus_req,
   input wire logic        bus_gnt,
   input wire logic        bus_rdy,
   input wire logic [23:0] bus_addr,
   input wire logic        bus_we,
   input wire logic [7:0]  bus_wdata,
   input wire logic [7:0]  bus_rdata
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // read byte handed over by the slave
   sequence s_rd_acc;
      bus_req && !bus_we && bus_gnt && bus_rdy;
   endsequence
   // the same byte goes out as a write, or the write is refused
   sequence s_wr_follow;
      !bus_req || (bus_we && bus_wdata == $past(bus_rdata));
   endsequence
   chk_apb_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
      else $error("apb answer not one wait state");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("slave error without ready or with data");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer cycle");
   chk_req_hold: assert property (bus_req && !(bus_gnt && bus_rdy)
      |=> bus_req && $stable(bus_addr) && $stable(bus_we) && $stable(bus_wdata))
      else $error("bus request changed before accept");
   chk_copy_byte: assert property (s_rd_acc |=> s_wr_follow)
      else $error("written byte differs from byte read");
   chk_no_ee_write: assert property (bus_req && bus_we |-> bus_addr < 24'h001000
      || bus_addr > 24'h001fff)
      else $error("write into eeprom window");
   chk_write_next: assert property (bus_req && bus_we && bus_gnt && bus_rdy |=> !bus_we)
      else $error("write not followed by read or idle");
endmodule // tct_dma_asserts
`default_nettype wire

// *** tct_mem_model.sv ***
// data bus partner: arbiter grant, slave ready and byte memory in one array
// assumes addresses below 16k; slow mode withholds grant and ready at random
`timescale 1ns/1ps
`default_nettype none
module tct_mem_model (
   // clock and mode
   input wire logic        pclk,
   input wire logic        slow,
   // data bus
   input wire logic        bus_req,
   output var logic        bus_gnt,
   output var logic        bus_rdy,
   input wire logic [23:0] bus_addr,
   input wire logic        bus_we,
   input wire logic [7:0]  bus_wdata,
   output wire logic [7:0] bus_rdata
);
   logic [7:0] mem [0:16383]; // byte store
   logic [7:0] junk = 8'h00;  // changing filler, so a stale byte never looks right
   wire        acc = bus_req && bus_gnt && bus_rdy;
   initial begin
      for (int i = 0; i < 16384; i++) mem[i] = i[7:0] ^ 8'h3c;
      bus_gnt = 1'b1;
      bus_rdy = 1'b1;
   end
   // data only while a read is accepted
   assign bus_rdata = (acc && !bus_we) ? mem[bus_addr[13:0]] : junk;
   // grant taken away for the core at random, slave slow at random
   always @(posedge pclk) begin
      bus_gnt <= !slow || ($urandom % 4 != 0);
      bus_rdy <= !slow || ($urandom % 3 != 0);
      junk <= junk + 8'h5b;
      if (acc && bus_we) mem[bus_addr[13:0]] <= bus_wdata;
   end
endmodule // tct_mem_model
`default_nettype wire

// *** tct_dma_bench.sv ***
// self-checking bench: apb master, random channel moves checked against the byte memory
// assumes tct_mem_model on the data bus and tct_dma_asserts bound at the foot
`include "tct_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module tct_dma_bench;
   logic        pclk = 1'b0, presetn = 1'b0, slow = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err_q;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic        bus_req, bus_gnt, bus_rdy, bus_we;
   logic [23:0] bus_addr;
   logic [7:0]  bus_wdata, bus_rdata;
   logic [7:0]  periph_trig = 8'h00;
   logic [3:0]  evt_trig = 4'h0;
   logic [7:0]  expm [int]; // expected bytes by address
   int          n_mismatch = 0, n_tests = 0, cyc = 0;
   tct_dma i_tct_dma (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bus_req(bus_req), .bus_gnt(bus_gnt), .bus_rdy(bus_rdy),
      .bus_addr(bus_addr), .bus_we(bus_we), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .periph_trig(periph_trig), .evt_trig(evt_trig));
   tct_mem_model i_tct_mem_model (.pclk(pclk), .slow(slow), .bus_req(bus_req),
      .bus_gnt(bus_gnt), .bus_rdy(bus_rdy), .bus_addr(bus_addr), .bus_we(bus_we),
      .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));
   always #4 pclk = ~pclk;
   // hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 90000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task check(input string what, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask
   // one apb transfer, held until pready is seen at an edge
   // no cycle count assumed here: only the hang guard ends a wait
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin @(posedge pclk); end while (pready !== 1'b1);
      q = prdata;
      err_q = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   function logic [23:0] step(input logic [23:0] a, input logic [1:0] m);
      return m == `TCT_AM_INC ? a + 24'h1 : m == `TCT_AM_DEC ? a - 24'h1 : a;
   endfunction
   // program one channel, trigger it to the end and check its registers
   task run(input int ch, input logic [1:0] ts, input logic rl, input logic lk, input logic ee);
      logic [7:0] b;
      logic [23:0] s, d, s0, d0;
      logic [1:0] sm, dm, bu;
      logic [31:0] ctl;
      int cnt, rep;
      b = 8'h20 * (ch + 1);
      s0 = ($urandom % 2 ? 24'h002000 : 24'h000800) + $urandom % 256;
      d0 = ee ? 24'h001010 : ($urandom % 2 ? 24'h003000 : 24'h000c00) + $urandom % 256;
      sm = $urandom % 3; dm = $urandom % 3; bu = $urandom % 4;
      cnt = (ch == 3) ? 1 : 1 + $urandom % 9; // single byte block under any burst
      rep = $urandom % 3;
      slow <= $urandom % 2;
      apb(1, b + `TCT_SRC, s0); apb(1, b + `TCT_DST, d0);
      apb(1, b + `TCT_CNT, cnt); apb(1, b + `TCT_REP, rep);
      s = s0; d = d0;
      for (int k = 0; k < cnt * (rep + 1) && !ee; k++) begin
         expm[d] = s[7:0] ^ 8'h3c;
         s = step(s, sm); d = step(d, dm);
      end
      ctl = {20'h0, ts == `TCT_TS_SW, lk, ts, bu, dm, sm, rl, 1'b1};
      apb(1, b, ctl);
      if (ts == `TCT_TS_PER0) periph_trig[2*ch] <= 1'b1;
      if (ts == `TCT_TS_PER1) periph_trig[2*ch+1] <= 1'b1;
      if (ts == `TCT_TS_EVT) evt_trig[ch] <= 1'b1;
      for (int t = 0; t < 400; t++) begin
         apb(0, b + `TCT_STAT, 0);
         if (q[1:0] != 2'b00) break;
         if (ts == `TCT_TS_SW && q[3:2] == 2'b00) apb(1, b, ctl);
      end
      periph_trig <= 8'h00; evt_trig <= 4'h0;
      check("stat", ee ? 2 : 1, q[1:0]);
      apb(0, b, 0); check("ctrl", ctl & 32'h7fe, q);
      if (lk) begin apb(0, 8'h20 * ((ch ^ 1) + 1), 0); check("link", 1, q[0]); end
      if (!ee) begin
         apb(0, b + `TCT_SRC, 0); check("src", rl ? s0 : s, q);
         apb(0, b + `TCT_DST, 0); check("dst", rl ? d0 : d, q);
         apb(0, b + `TCT_CNT, 0); check("cnt", cnt, q);
         apb(0, b + `TCT_REP, 0); check("rep", rep, q);
      end
      apb(1, b + `TCT_STAT, 3); apb(0, b + `TCT_STAT, 0); check("clear", 0, q[1:0]);
   endtask
   initial begin
      void'($urandom(32'ha59a));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, `TCT_GCTRL, 0); check("gctrl", 0, q);
      apb(0, 8'hc0, 0); check("unmapped err", 1, err_q);
      check("unmapped data", 0, q);
      apb(1, `TCT_GCTRL, 5);
      for (int i = 0; i < 16; i++) begin
         if (i == 8) apb(1, `TCT_GCTRL, 7); // round robin
         // link only where the partner holds no leftover pending trigger
         run(i % 4, (i + i / 4) % 4, i[0], i == 1, i == 14);
      end
      // eeprom source with the window unmapped: refused before any bus request
      apb(1, `TCT_GCTRL, 1);
      apb(1, 8'h20 + `TCT_SRC, 32'h00001010);
      apb(1, 8'h20, 32'h00000801);
      repeat (4) @(posedge pclk);
      apb(0, 8'h20 + `TCT_STAT, 0); check("ee unmapped", 2, q[1:0]);
      apb(0, `TCT_GSTAT, 0); check("gstat", 32'h00000010, q);
      foreach (expm[a]) check("mem", expm[a], i_tct_mem_model.mem[a[13:0]]);
      tally_and_finish();
   end
endmodule // tct_dma_bench
bind tct_dma tct_dma_asserts i_tct_dma_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .bus_req(bus_req), .bus_gnt(bus_gnt), .bus_rdy(bus_rdy), .bus_addr(bus_addr),
   .bus_we(bus_we), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));
`default_nettype wire
